/* pwr_seq_defines.svh */
/*
 * Constants of the power state sequencer: register offsets, field
 * positions, reset values and debounce times.
 * Assumes a 20 MHz reference clock and a 32-bit AHB-Lite register bus.
 */
`ifndef PWR_SEQ_DEFINES_SVH
`define PWR_SEQ_DEFINES_SVH

// ****************************************************************
// Clock and times
// ****************************************************************
`define REF_CLK_MHZ       20
`define DB_SHORT_US       31250
`define DB_MID_US         125000
`define DB_LONG_US        750000
`define LONG_PRESS_US     4000000

// ****************************************************************
// Register map
// ****************************************************************
`define ADDR_DEC_W        12
`define REG_CTRL          12'h000
`define REG_STATUS        12'h004

`define CTRL_STYLE_BIT    0
`define CTRL_LPOFF_BIT    1
`define CTRL_DBSEL_LSB    2
`define CTRL_RESTART_BIT  4
`define CTRL_KEEP_LSB     8

`define STAT_STATE_LSB    0
`define STAT_SENSE_BIT    8
`define STAT_FLAG_BIT     9
`define STAT_UV_BIT       10
`define STAT_THERM_BIT    11
`define STAT_STBY_BIT     12

`define DBSEL_RESET       2'h0

`endif

/* pwr_seq_pkg.sv */
/*
 * Types of the power state sequencer.
 * Assumes nothing beyond the constants header.
 */
package pwr_seq_pkg;

   // ****************************************************************
   // Power states, one-hot
   // ****************************************************************
   typedef enum logic [4:0] {
      ST_OFF   = 5'b00001,
      ST_COIN  = 5'b00010,
      ST_SLEEP = 5'b00100,
      ST_STBY  = 5'b01000,
      ST_ON    = 5'b10000
   } pstate_t;

   typedef enum logic [1:0] {
      DB_NONE_SHORT = 2'b00,
      DB_SHORT      = 2'b01,
      DB_MID        = 2'b10,
      DB_LONG       = 2'b11
   } dbsel_t;

endpackage : pwr_seq_pkg

/* power_state_sequencer.sv */
/*
 * Power state sequencer: OFF, Coin Cell, Sleep, Standby and ON states,
 * power-on pin debouncer, turn-on flag, long-press off, AHB-Lite slave.
 * Assumes pins and comparator levels arrive asynchronously; the standby
 * request is already polarity-qualified; single-word AHB-Lite master.
 */
// Added by the designer: the AHB-Lite interface to the registers and the register offsets.
`include "pwr_seq_defines.svh"

module power_state_sequencer
   import pwr_seq_pkg::*;
#(
   parameter int unsigned NREG         = 4,
   parameter int unsigned CNT_W        = 27,
   parameter int unsigned DB_SHORT_CYC = `DB_SHORT_US * `REF_CLK_MHZ,
   parameter int unsigned DB_MID_CYC   = `DB_MID_US * `REF_CLK_MHZ,
   parameter int unsigned DB_LONG_CYC  = `DB_LONG_US * `REF_CLK_MHZ,
   parameter int unsigned LONG_CYC     = `LONG_PRESS_US * `REF_CLK_MHZ
)
(
   input  wire logic        ref_clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   input  wire logic        power_on_pin_i,
   input  wire logic        supply_ok_i,
   input  wire logic        thermal_trip_i,
   input  wire logic        standby_req_i,
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic      [31:0] hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o,
   output logic      [4:0]  power_state_o,
   output logic             startup_seq_o
);

   // ****************************************************************
   // Parameter checks
   // ****************************************************************
   generate
      if (NREG < 1 || NREG > 8 || LONG_CYC + 1 >= (64'd1 << CNT_W) ||
          DB_SHORT_CYC > LONG_CYC || DB_MID_CYC > LONG_CYC || DB_LONG_CYC > LONG_CYC)
      begin : g_bad_param
         $error("power_state_sequencer: unsupported parameter values");
      end
   endgenerate

   localparam logic [CNT_W-1:0] SAT_LOW  = CNT_W'(LONG_CYC + 1);
   localparam logic [CNT_W-1:0] SAT_HIGH = CNT_W'(DB_SHORT_CYC + 1);

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic [1:0]       pin_sy;
      logic [1:0]       uv_sy;
      logic [1:0]       th_sy;
      logic [1:0]       sb_sy;
      pstate_t          st;
      logic [CNT_W-1:0] lowcnt;
      logic [CNT_W-1:0] hicnt;
      logic             style;
      logic             lp_en;
      dbsel_t           dbsel;
      logic             restart_en;
      logic [NREG-1:0]  keep;
      logic             flag;
      logic             restart_pend;
      logic             seq_start;
      logic             wr_pend;
      logic [`ADDR_DEC_W-1:0] wr_addr;
      logic [31:0]      rdata;
      logic             ready;
      logic             resp;
   } seq_regs_t;

   seq_regs_t q;
   seq_regs_t d;

   logic             pin;
   logic             uv;
   logic             th;
   logic             sb;
   logic [CNT_W-1:0] ton_cyc;
   logic [CNT_W-1:0] fall_cyc;
   logic             press_evt;
   logic             fall_evt;
   logic             rise_evt;
   logic             long_evt;
   logic             turn_on;
   logic             off_req;
   logic             long_off;
   logic             any_keep;
   logic             addr_ph;
   logic [31:0]      status;

   // ****************************************************************
   // Next-state logic
   // ****************************************************************
   always_comb
   begin
      d        = q;
      // Only stage one of each synchroniser looks at the raw level
      d.pin_sy = {q.pin_sy[0], power_on_pin_i};
      d.uv_sy  = {q.uv_sy[0], supply_ok_i};
      d.th_sy  = {q.th_sy[0], thermal_trip_i};
      d.sb_sy  = {q.sb_sy[0], standby_req_i};
      pin      = q.pin_sy[1];
      uv       = q.uv_sy[1];
      th       = q.th_sy[1];
      sb       = q.sb_sy[1];
      any_keep = |q.keep;

      case (q.dbsel)
         DB_NONE_SHORT:
         begin
            ton_cyc  = '0;
            fall_cyc = CNT_W'(DB_SHORT_CYC);
         end
         DB_SHORT:
         begin
            ton_cyc  = CNT_W'(DB_SHORT_CYC);
            fall_cyc = CNT_W'(DB_SHORT_CYC);
         end
         DB_MID:
         begin
            ton_cyc  = CNT_W'(DB_MID_CYC);
            fall_cyc = CNT_W'(DB_MID_CYC);
         end
         DB_LONG:
         begin
            ton_cyc  = CNT_W'(DB_LONG_CYC);
            fall_cyc = CNT_W'(DB_LONG_CYC);
         end
         default:
         begin
            ton_cyc  = '0;
            fall_cyc = CNT_W'(DB_SHORT_CYC);
         end
      endcase

      // Each count value is passed once, so every event is one cycle
      press_evt = !pin && q.lowcnt == ton_cyc;
      fall_evt  = !pin && q.lowcnt == fall_cyc;
      long_evt  = !pin && q.lowcnt == CNT_W'(LONG_CYC);
      rise_evt  = pin && q.hicnt == CNT_W'(DB_SHORT_CYC);
      d.lowcnt  = pin ? '0 : (q.lowcnt == SAT_LOW ? q.lowcnt : q.lowcnt + CNT_W'(1));
      d.hicnt   = !pin ? '0 : (q.hicnt == SAT_HIGH ? q.hicnt : q.hicnt + CNT_W'(1));

      turn_on  = q.style ? press_evt : pin;
      long_off = q.style && q.lp_en && long_evt;
      off_req  = q.style ? long_off : !pin;

      case (q.st)
         ST_COIN:
            if (uv)
               d.st = ST_OFF;
         ST_OFF:
            if (!uv)
               d.st = ST_COIN;
            else if (!th && (turn_on || q.restart_pend))
               d.st = ST_ON;
         ST_SLEEP:
            if (!uv)
               d.st = ST_COIN;
            else if (th || long_off)
               d.st = ST_OFF;
            else if (turn_on)
               d.st = ST_ON;
         ST_STBY, ST_ON:
            if (!uv)
               d.st = ST_COIN;
            else if (th)
               d.st = ST_OFF;
            else if (off_req)
               d.st = any_keep ? ST_SLEEP : ST_OFF;
            else if (q.st == ST_ON && sb)
               d.st = ST_STBY;
            else if (q.st == ST_STBY && !sb)
               d.st = ST_ON;
         default:
            d.st = ST_COIN;
      endcase

      // A held long press that ends in OFF with restart enabled comes straight back on
      if (d.st == ST_OFF && q.st != ST_OFF)
         d.restart_pend = long_off && q.restart_en;
      else if (q.st == ST_OFF && d.st != ST_OFF)
         d.restart_pend = 1'b0;

      // Sleep wake-up leaves the running regulators alone
      d.seq_start = q.st == ST_OFF && d.st == ST_ON;

      // ****************************************************************
      // Register bus
      // ****************************************************************
      status = '0;
      status[`STAT_STATE_LSB +: 5] = q.st;
      status[`STAT_SENSE_BIT]      = pin;
      status[`STAT_FLAG_BIT]       = q.flag;
      status[`STAT_UV_BIT]         = uv;
      status[`STAT_THERM_BIT]      = th;
      status[`STAT_STBY_BIT]       = sb;

      addr_ph   = hsel_i && htrans_i[1] && hready_i;
      d.wr_pend = addr_ph && hwrite_i;
      d.wr_addr = haddr_i[`ADDR_DEC_W-1:0];
      d.rdata   = '0;
      d.ready   = 1'b1;
      d.resp    = 1'b0;
      if (addr_ph && !hwrite_i)
      begin
         if (haddr_i[`ADDR_DEC_W-1:0] == `REG_CTRL)
         begin
            d.rdata[`CTRL_STYLE_BIT]           = q.style;
            d.rdata[`CTRL_LPOFF_BIT]           = q.lp_en;
            d.rdata[`CTRL_DBSEL_LSB +: 2]      = q.dbsel;
            d.rdata[`CTRL_RESTART_BIT]         = q.restart_en;
            d.rdata[`CTRL_KEEP_LSB +: NREG]    = q.keep;
         end
         else if (haddr_i[`ADDR_DEC_W-1:0] == `REG_STATUS)
            d.rdata = status;
      end

      if (q.wr_pend && q.wr_addr == `REG_CTRL)
      begin
         d.style      = hwdata_i[`CTRL_STYLE_BIT];
         d.lp_en      = hwdata_i[`CTRL_LPOFF_BIT];
         d.dbsel      = dbsel_t'(hwdata_i[`CTRL_DBSEL_LSB +: 2]);
         d.restart_en = hwdata_i[`CTRL_RESTART_BIT];
         d.keep       = hwdata_i[`CTRL_KEEP_LSB +: NREG];
      end

      // Clear first, so a same-cycle pin event still wins
      if (q.wr_pend && q.wr_addr == `REG_STATUS && hwdata_i[`STAT_FLAG_BIT])
         d.flag = 1'b0;
      if (d.st == ST_OFF && q.st != ST_OFF)
         d.flag = 1'b0;
      if (fall_evt || rise_evt || d.seq_start ||
          (q.st == ST_SLEEP && d.st == ST_ON))
         d.flag = 1'b1;
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         q        <= '0;
         q.st     <= ST_COIN;
         q.lowcnt <= SAT_LOW;
         q.hicnt  <= SAT_HIGH;
         q.dbsel  <= dbsel_t'(`DBSEL_RESET);
         q.ready  <= 1'b1;
      end
      else if (ce_i)
         q <= d;
   end

   assign hrdata_o      = q.rdata;
   assign hreadyout_o   = q.ready;
   assign hresp_o       = q.resp;
   assign power_state_o = q.st;
   assign startup_seq_o = q.seq_start;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i || !ce_i);

   coin_entry_a: assert property (q.st != ST_COIN && !q.uv_sy[1] |=> q.st == ST_COIN)
      else $error("undervoltage did not reach coin cell");
   coin_exit_a: assert property (q.st == ST_COIN && q.uv_sy[1] |=> q.st == ST_OFF)
      else $error("coin cell did not leave on good supply");
   thermal_off_a: assert property ((q.st inside {ST_SLEEP, ST_STBY, ST_ON}) && q.uv_sy[1]
      && q.th_sy[1] |=> q.st == ST_OFF)
      else $error("thermal trip did not force off");
   no_hot_on_a: assert property (q.st == ST_OFF && q.th_sy[1] |=> q.st != ST_ON)
      else $error("turn-on accepted during thermal trip");
   level_on_a: assert property (q.st == ST_OFF && !q.style && q.pin_sy[1] && q.uv_sy[1]
      && !q.th_sy[1] |=> q.st == ST_ON && q.flag)
      else $error("level turn-on missed");
   off_entry_a: assert property (q.st == ST_OFF && $past(q.st) != ST_OFF |-> !q.restart_pend
      || $past(q.restart_en))
      else $error("restart armed without enable");
   wake_keep_a: assert property (q.st == ST_SLEEP ##1 q.st == ST_ON |-> !q.seq_start
      && q.flag)
      else $error("sleep wake-up reran start-up");
   cold_start_a: assert property (q.st == ST_OFF ##1 q.st == ST_ON |-> q.seq_start)
      else $error("start-up not signalled");
   stby_enter_a: assert property (q.st == ST_STBY && $past(q.st) == ST_ON |->
      $past(q.sb_sy[1]))
      else $error("standby entered without request");
   long_off_a: assert property (q.st == ST_ON && q.style && q.lp_en && !q.pin_sy[1]
      && q.lowcnt == CNT_W'(LONG_CYC) |=> q.st != ST_ON)
      else $error("long press did not power down");
   push_on_a: assert property (q.st == ST_OFF && q.style && q.uv_sy[1] && !q.th_sy[1]
      && !q.pin_sy[1] && q.lowcnt == ton_cyc |=> q.st == ST_ON)
      else $error("debounced press did not turn on");

endmodule : power_state_sequencer

/* pwr_button_model.sv */
/*
 * Model of the push-button or host that drives the power-on pin.
 * Assumes the caller's clock is the sequencer's clock; pin idles high.
 */
module pwr_button_model
(
   input  wire logic clk_i,
   output logic      pin_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // ********************************
   // Pin drive
   // ********************************
   // Pull-up to the backup rail holds a released pin high
   initial pin_o = 1'b1;

   task automatic drive(input logic level);
      @(posedge clk_i);
      pin_o <= level;
   endtask : drive

   // Press pulls low for n cycles, then releases
   task automatic press(input int n);
      drive(1'b0);
      repeat (n) @(posedge clk_i);
      pin_o <= 1'b1;
   endtask : press
endmodule : pwr_button_model

/* tb_power_state_sequencer.sv */
/*
 * Self-checking bench of the power state sequencer over AHB-Lite.
 * Assumes shortened debounce counts and a zero-wait-state slave.
 */
`include "pwr_seq_defines.svh"

module tb_power_state_sequencer
   import pwr_seq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // ********************************
   // Signals and instances
   // ********************************
   localparam logic [31:0] FLAG  = 32'h1 << `STAT_FLAG_BIT;
   localparam logic [31:0] SENSE = 32'h1 << `STAT_SENSE_BIT;
   localparam int          LIMIT = 20000;
   logic        ref_clk_i     = 1'b0;
   logic        rst_i         = 1'b1;
   logic        ce_i          = 1'b1;
   logic        hsel_i        = 1'b1;
   logic        supply_ok_i   = 1'b0;
   logic        therm_i       = 1'b0;
   logic        stby_i        = 1'b0;
   logic [1:0]  htrans_i      = 2'b00;
   logic [31:0] haddr_i       = 32'h0;
   logic        hwrite_i      = 1'b0;
   logic [2:0]  hsize_i       = 3'h0;
   logic [31:0] hwdata_i      = 32'h0;
   logic [31:0] hrdata_o;
   logic        hreadyout_o;
   logic [4:0]  power_state_o;
   logic        startup_seq_o;
   logic        hresp_o;
   logic        pin;
   int          miscompares   = 0;
   int          n_compared    = 0;
   int          n_start       = 0;
   int          cycles        = 0;
   int          t_on[4]       = '{0, 20, 40, 60};

   always #25 ref_clk_i = ~ref_clk_i;

   pwr_button_model btn (.clk_i(ref_clk_i), .pin_o(pin));

   power_state_sequencer #(.DB_SHORT_CYC(20), .DB_MID_CYC(40), .DB_LONG_CYC(60),
                           .LONG_CYC(100)) dut
   (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce_i), .power_on_pin_i(pin),
      .supply_ok_i(supply_ok_i), .thermal_trip_i(therm_i), .standby_req_i(stby_i),
      .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
      .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
      .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
      .power_state_o(power_state_o), .startup_seq_o(startup_seq_o)
   );

   // Pulse counted at the falling edge, so a check at the next rising edge sees it
   always @(negedge ref_clk_i)
   begin
      if (startup_seq_o === 1'b1)
         n_start <= n_start + 1;
   end

   always @(posedge ref_clk_i)
   begin
      cycles <= cycles + 1;
      if (cycles == LIMIT)
      begin
         miscompares++;
         finish_test();
      end
   end

   // ********************************
   // Tasks
   // ********************************
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // Single word transfer; waits on hready, no assumed latency
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      @(posedge ref_clk_i);
      htrans_i <= 2'b10;
      haddr_i  <= {20'h0, a};
      hwrite_i <= wr;
      hsize_i  <= 3'h2;
      do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1);
      htrans_i <= 2'b00;
      hwdata_i <= wd;
      do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1);
      rd = hrdata_o;
   endtask : bus

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] rd;
      bus(1'b1, a, d, rd);
   endtask : wr

   task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] mask,
                       input logic [31:0] exp);
      logic [31:0] rd;
      bus(1'b0, a, 32'h0, rd);
      check(what, rd & mask, exp);
      check("okay response", {31'h0, hresp_o}, 32'h0);
   endtask : rchk

   // Bounded wait, then compare; a hang only costs lim cycles
   task automatic wait_st(input pstate_t s, input int lim);
      for (int i = 0; i < lim && power_state_o !== s; i++)
         @(posedge ref_clk_i);
      check("state", {27'h0, power_state_o}, {27'h0, s});
   endtask : wait_st

   task automatic finish_test();
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : finish_test

   // ********************************
   // Test sequence
   // ********************************
   initial
   begin
      int n;
      repeat (20) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      @(posedge ref_clk_i);
      check("reset state", {27'h0, power_state_o}, {27'h0, ST_COIN});
      rchk("ctrl reset", `REG_CTRL, 32'hffffffff, 32'h0);
      // Deselected write must leave the control word alone
      hsel_i <= 1'b0;
      wr(`REG_CTRL, 32'h1f);
      hsel_i <= 1'b1;
      rchk("deselected", `REG_CTRL, 32'hffffffff, 32'h0);
      rchk("unmapped", 12'h0f0, 32'hffffffff, 32'h0);
      supply_ok_i <= 1'b1;
      wait_st(ST_ON, 20);
      check("startups", n_start, 1);
      rchk("flag on", `REG_STATUS, FLAG, FLAG);
      rchk("sense hi", `REG_STATUS, SENSE, SENSE);
      wr(`REG_STATUS, FLAG);
      rchk("flag clr", `REG_STATUS, FLAG, 32'h0);
      btn.drive(1'b0);
      wait_st(ST_OFF, 10);
      rchk("sense lo", `REG_STATUS, SENSE, 32'h0);
      btn.drive(1'b1);
      wait_st(ST_ON, 10);
      // Clock enable low freezes the machine; request acts once it returns
      ce_i   <= 1'b0;
      stby_i <= 1'b1;
      repeat (10) @(posedge ref_clk_i);
      check("frozen", {27'h0, power_state_o}, {27'h0, ST_ON});
      ce_i   <= 1'b1;
      wait_st(ST_STBY, 10);
      stby_i <= 1'b0;
      wait_st(ST_ON, 10);
      wr(`REG_CTRL, 32'h1 << `CTRL_KEEP_LSB);
      n = n_start;
      btn.drive(1'b0);
      wait_st(ST_SLEEP, 10);
      btn.drive(1'b1);
      wait_st(ST_ON, 10);
      check("no restart", n_start, n);
      therm_i <= 1'b1;
      wait_st(ST_OFF, 10);
      repeat (20) @(posedge ref_clk_i);
      check("held off", {27'h0, power_state_o}, {27'h0, ST_OFF});
      therm_i <= 1'b0;
      wait_st(ST_ON, 10);
      // Push-button: long press off, short press ignored when a turn-on debounce is set, press turns on
      for (int s = 0; s < 4; s++)
      begin
         wr(`REG_CTRL, 32'h3 | (s << `CTRL_DBSEL_LSB));
         btn.press(120);
         wait_st(ST_OFF, 10);
         rchk("off clears", `REG_STATUS, FLAG, 32'h0);
         if (s > 0)
         begin
            btn.press(t_on[s] - 5);
            repeat (20) @(posedge ref_clk_i);
            check("short press", {27'h0, power_state_o}, {27'h0, ST_OFF});
         end
         btn.press(t_on[s] + 10);
         wait_st(ST_ON, 20);
      end
      // Edge flags with the longest falling debounce
      wr(`REG_STATUS, FLAG);
      btn.drive(1'b0);
      repeat (30) @(posedge ref_clk_i);
      rchk("fall early", `REG_STATUS, FLAG | SENSE, 32'h0);
      repeat (40) @(posedge ref_clk_i);
      rchk("fall flag", `REG_STATUS, FLAG, FLAG);
      btn.drive(1'b1);
      wr(`REG_STATUS, FLAG);
      repeat (10) @(posedge ref_clk_i);
      rchk("rise early", `REG_STATUS, FLAG, 32'h0);
      repeat (20) @(posedge ref_clk_i);
      rchk("rise flag", `REG_STATUS, FLAG, FLAG);
      supply_ok_i <= 1'b0;
      wait_st(ST_COIN, 10);
      btn.press(80);
      check("coin hold", {27'h0, power_state_o}, {27'h0, ST_COIN});
      supply_ok_i <= 1'b1;
      wait_st(ST_OFF, 10);
      repeat (30) @(posedge ref_clk_i);
      check("no press", {27'h0, power_state_o}, {27'h0, ST_OFF});
      finish_test();
   end
endmodule : tb_power_state_sequencer
